// >>> logic/dual_pwm_pkg.sv
/*
  Constants, field layouts and helpers shared by the PWM unit files.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package dual_pwm_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FINE_PERIOD  = 8'h92;
  localparam logic [7:0] IDX_FINE_DUTY_H  = 8'h93;
  localparam logic [7:0] IDX_FINE_DUTY_L  = 8'h94;
  localparam logic [7:0] IDX_FINE_CTRL    = 8'h95;
  localparam logic [7:0] IDX_CLOCK_CTRL   = 8'h96;
  localparam logic [7:0] IDX_TRIPLE_PER   = 8'h97;
  localparam logic [7:0] IDX_TRIPLE_A     = 8'h98;
  localparam logic [7:0] IDX_TRIPLE_B     = 8'h99;
  localparam logic [7:0] IDX_TRIPLE_C     = 8'h9a;
  localparam logic [7:0] IDX_TRIPLE_ROUTE = 8'h9b;
  localparam logic [7:0] IDX_MISC_ROUTE   = 8'h9c;
  localparam logic [7:0] IDX_STATUS       = 8'h9d;

  // Reset values
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] REG_RESET    = 8'h00;

  // Fine channel control fields
  localparam int CLR_BIT  = 5;
  localparam int MODE_LSB = 3;
  localparam int NOV_LSB  = 0;

  // Clock control fields
  localparam int DIS_TRIPLE_BIT = 7;
  localparam int DIS_FINE_BIT   = 6;
  localparam int CKS_LSB        = 4;
  localparam int PSC_TRIPLE_LSB = 2;
  localparam int PSC_FINE_LSB   = 0;

  // Routing bits of the triple routing register
  localparam int C_ROUTE1 = 7;
  localparam int C_ROUTE0 = 6;
  localparam int B_ROUTE2 = 5;
  localparam int B_ROUTE1 = 4;
  localparam int B_ROUTE0 = 3;
  localparam int A_ROUTE2 = 2;
  localparam int A_ROUTE1 = 1;
  localparam int A_ROUTE0 = 0;

  // Routing bits of the misc routing register
  localparam int C_ROUTE3 = 5;
  localparam int C_ROUTE2 = 4;
  localparam int NEG_ROUTE1 = 3;
  localparam int NEG_ROUTE0 = 2;
  localparam int POS_ROUTE1 = 1;
  localparam int POS_ROUTE0 = 0;

  // Pin vector positions
  localparam int PIN_PA0  = 0;
  localparam int PIN_PA3  = 1;
  localparam int PIN_PA4  = 2;
  localparam int PIN_PA5  = 3;
  localparam int PIN_PB0  = 4;
  localparam int PIN_PB1  = 5;
  localparam int PIN_PD1  = 6;
  localparam int PIN_PD2  = 7;
  localparam int PIN_PD3  = 8;
  localparam int PIN_PD7  = 9;
  localparam int NUM_PINS = 10;

  typedef enum logic [1:0] {
    MODE_DIRECT, MODE_INVERTED, MODE_SWAPPED, MODE_SWAP_INV
  } out_mode_t;

  // Terminal count of a prescaler: divide by 1, 2, 4 or 64
  function automatic logic [5:0] presc_limit(input logic [1:0] code);
    case (code)
      2'b00:   presc_limit = 6'h00;
      2'b01:   presc_limit = 6'h01;
      2'b10:   presc_limit = 6'h03;
      default: presc_limit = 6'h3f;
    endcase
  endfunction

  // Non-overlap gap in channel clocks; unused codes give no gap
  function automatic logic [3:0] nov_gap(input logic [2:0] code);
    case (code)
      3'b001:  nov_gap = 4'h4;
      3'b010:  nov_gap = 4'h5;
      3'b011:  nov_gap = 4'h6;
      3'b100:  nov_gap = 4'h7;
      3'b101:  nov_gap = 4'h8;
      default: nov_gap = 4'h0;
    endcase
  endfunction

endpackage

// >>> logic/dual_pwm_unit.sv
/*
  Dual PWM unit: APB register file, clock source and prescalers, the
  shared-period triple 8-bit part, and pin routing with fixed priority.
  Assumes pclk at 50 MHz, osc tick inputs as one-cycle enables already
  synchronous to pclk, and an APB master that follows the usual phases.
*/
// Register access over APB was left to the implementer.
//
// What this block does
// - Fine channel has 1024 duty steps, 8-bit high and 2-bit low part.
// - Low bits spread over base cycles; repetition is clock over period plus one.
// - Fine output goes low when base count equals duty high part.
// - At rollover low bits choose set high now or one clock later.
// - Fine duty writes buffered to period end; period writes immediate.
// - Period below count: counter wraps through 255 then reaches period.
// - Complementary pair in four output modes; mode 0 after reset.
// - Non-overlap field gives gaps of 0, 4, 5, 6, 7, 8 clocks.
// - Fine clear bit set clears and holds the channel inactive.
// - Fine clock-disable bit stops the fine channel clock.
// - Shared source field: 0x system, 10 osc16, 11 osc32.
// - Each part prescales by 1, 2, 4 or 64.
// - Triple part: three 8-bit duties, one shared period and clock.
// - Triple outputs go low when shared count equals their duty.
// - Triple period writes immediate; count above it wraps first.
// - Triple disable bit stops its clock and clears its channels.
// - Fine channel wins a pin shared with a triple channel.
// - Four enables route fine outputs to PA0, PA4, PB0, PA3.
// - Triple channels route to three, three and four pins.
`timescale 1ns/1ns
module dual_pwm_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc16_tick,
  input  wire logic        osc32_tick,
  output logic      [9:0]  pin_out,
  output logic      [9:0]  pin_oe_n
);
  // Register storage
  logic [7:0] fine_period_value;
  logic [7:0] fine_duty_high;
  logic [1:0] fine_duty_low;
  logic [5:0] fine_channel_control;
  logic [7:0] pwm_clock_control;
  logic [7:0] triple_shared_period;
  logic [7:0] triple_a_duty;
  logic [7:0] triple_b_duty;
  logic [7:0] triple_c_duty;
  logic [7:0] triple_routing_reg;
  logic [7:0] misc_routing_reg;

  // Triple part state and both prescaler counters
  logic [7:0] triple_cnt;
  logic       out_a;
  logic       out_b;
  logic       out_c;
  logic [5:0] fine_psc;
  logic [5:0] triple_psc;

  fine_chan_if fc ();

  // APB decode: word aligned, upper bits clear, index in the map
  wire [7:0] idx      = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire       in_map   = (idx >= dual_pwm_pkg::IDX_FINE_PERIOD) &&
                        (idx <= dual_pwm_pkg::IDX_STATUS);
  wire       hit      = aligned && in_map;
  wire       access   = psel && penable;
  wire       wr       = access && pwrite && hit;
  wire [7:0] wbyte    = pwdata[7:0];

  // Zero wait state; unmapped or unaligned access answers an error
  assign pready  = 1'b1;
  assign pslverr = access && !hit;

  // Field views
  wire       fine_clear_hold    = fine_channel_control[dual_pwm_pkg::CLR_BIT];
  wire [1:0] fine_output_mode   =
    fine_channel_control[dual_pwm_pkg::MODE_LSB +: 2];
  wire [2:0] fine_nonoverlap_select =
    fine_channel_control[dual_pwm_pkg::NOV_LSB +: 3];
  wire       triple_clock_disable_clear =
    pwm_clock_control[dual_pwm_pkg::DIS_TRIPLE_BIT];
  wire       fine_clock_disable =
    pwm_clock_control[dual_pwm_pkg::DIS_FINE_BIT];
  wire [1:0] shared_clock_source =
    pwm_clock_control[dual_pwm_pkg::CKS_LSB +: 2];
  wire [1:0] triple_prescaler =
    pwm_clock_control[dual_pwm_pkg::PSC_TRIPLE_LSB +: 2];
  wire [1:0] fine_prescaler =
    pwm_clock_control[dual_pwm_pkg::PSC_FINE_LSB +: 2];

  // Register writes take effect at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_period_value <= dual_pwm_pkg::PERIOD_RESET;
      fine_duty_high <= dual_pwm_pkg::REG_RESET;
      fine_duty_low <= 2'b00;
      fine_channel_control <= 6'h00;
      pwm_clock_control <= dual_pwm_pkg::REG_RESET;
      triple_shared_period <= dual_pwm_pkg::PERIOD_RESET;
      triple_a_duty <= dual_pwm_pkg::REG_RESET;
      triple_b_duty <= dual_pwm_pkg::REG_RESET;
      triple_c_duty <= dual_pwm_pkg::REG_RESET;
      triple_routing_reg <= dual_pwm_pkg::REG_RESET;
      misc_routing_reg <= dual_pwm_pkg::REG_RESET;
    end else if (wr) begin
      case (idx)
        dual_pwm_pkg::IDX_FINE_PERIOD:  fine_period_value <= wbyte;
        dual_pwm_pkg::IDX_FINE_DUTY_H:  fine_duty_high <= wbyte;
        dual_pwm_pkg::IDX_FINE_DUTY_L:  fine_duty_low <= wbyte[1:0];
        dual_pwm_pkg::IDX_FINE_CTRL:    fine_channel_control <= wbyte[5:0];
        dual_pwm_pkg::IDX_CLOCK_CTRL:   pwm_clock_control <= wbyte;
        dual_pwm_pkg::IDX_TRIPLE_PER:   triple_shared_period <= wbyte;
        dual_pwm_pkg::IDX_TRIPLE_A:     triple_a_duty <= wbyte;
        dual_pwm_pkg::IDX_TRIPLE_B:     triple_b_duty <= wbyte;
        dual_pwm_pkg::IDX_TRIPLE_C:     triple_c_duty <= wbyte;
        dual_pwm_pkg::IDX_TRIPLE_ROUTE: triple_routing_reg <= wbyte;
        dual_pwm_pkg::IDX_MISC_ROUTE:   misc_routing_reg <= wbyte;
        default: ;
      endcase
    end
  end

  // Read selection; status shows both live counters and outputs
  wire [31:0] status_word = {11'h000, out_c, out_b, out_a,
                             fc.fine_negative_output,
                             fc.fine_positive_output,
                             triple_cnt, fc.count};
  wire [31:0] rd_word =
    (idx == dual_pwm_pkg::IDX_FINE_PERIOD)  ? {24'h0, fine_period_value} :
    (idx == dual_pwm_pkg::IDX_FINE_DUTY_H)  ? {24'h0, fine_duty_high} :
    (idx == dual_pwm_pkg::IDX_FINE_DUTY_L)  ? {30'h0, fine_duty_low} :
    (idx == dual_pwm_pkg::IDX_FINE_CTRL)    ? {26'h0, fine_channel_control} :
    (idx == dual_pwm_pkg::IDX_CLOCK_CTRL)   ? {24'h0, pwm_clock_control} :
    (idx == dual_pwm_pkg::IDX_TRIPLE_PER)   ? {24'h0, triple_shared_period} :
    (idx == dual_pwm_pkg::IDX_TRIPLE_A)     ? {24'h0, triple_a_duty} :
    (idx == dual_pwm_pkg::IDX_TRIPLE_B)     ? {24'h0, triple_b_duty} :
    (idx == dual_pwm_pkg::IDX_TRIPLE_C)     ? {24'h0, triple_c_duty} :
    (idx == dual_pwm_pkg::IDX_TRIPLE_ROUTE) ? {24'h0, triple_routing_reg} :
    (idx == dual_pwm_pkg::IDX_MISC_ROUTE)   ? {24'h0, misc_routing_reg} :
    (idx == dual_pwm_pkg::IDX_STATUS)       ? status_word : 32'h0;

  // Read data is captured in the setup phase so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= (hit && !pwrite) ? rd_word : 32'h0;
    end
  end

  // Source select: system clock runs every cycle, oscillators by tick
  wire src_tick = shared_clock_source[1] ?
                  (shared_clock_source[0] ? osc32_tick : osc16_tick) :
                  1'b1;

  wire [5:0] fine_lim   = dual_pwm_pkg::presc_limit(fine_prescaler);
  wire [5:0] triple_lim = dual_pwm_pkg::presc_limit(triple_prescaler);
  wire fine_tick   = src_tick && !fine_clock_disable &&
                     (fine_psc == fine_lim);
  wire triple_tick = src_tick && !triple_clock_disable_clear &&
                     (triple_psc == triple_lim);

  // Prescaler counters; a disabled part holds its prescaler at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_psc <= 6'h00;
      triple_psc <= 6'h00;
    end else begin
      if (fine_clock_disable || fine_tick) begin
        fine_psc <= 6'h00;
      end else if (src_tick) begin
        fine_psc <= fine_psc + 6'h01;
      end
      if (triple_clock_disable_clear || triple_tick) begin
        triple_psc <= 6'h00;
      end else if (src_tick) begin
        triple_psc <= triple_psc + 6'h01;
      end
    end
  end

  // Fine channel hookup
  assign fc.tick   = fine_tick;
  assign fc.clear  = fine_clear_hold;
  assign fc.mode   = fine_output_mode;
  assign fc.nov    = fine_nonoverlap_select;
  assign fc.period = fine_period_value;
  assign fc.duty_h = fine_duty_high;
  assign fc.duty_l = fine_duty_low;

  fine_pwm_channel u_fine (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (fc.chan)
  );

  // Triple part: one counter, three compares, period applies at once
  wire       triple_roll = (triple_cnt == triple_shared_period);
  wire [7:0] triple_inc  = triple_cnt + 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      triple_cnt <= 8'h00;
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
    end else if (triple_clock_disable_clear) begin
      triple_cnt <= 8'h00;
      out_a <= 1'b0;
      out_b <= 1'b0;
      out_c <= 1'b0;
    end else if (triple_tick) begin
      if (triple_roll) begin
        triple_cnt <= 8'h00;
        out_a <= (triple_a_duty != 8'h00);
        out_b <= (triple_b_duty != 8'h00);
        out_c <= (triple_c_duty != 8'h00);
      end else begin
        // Wraps through 255 when the period was set below the count
        triple_cnt <= triple_inc;
        if (triple_inc == triple_a_duty) out_a <= 1'b0;
        if (triple_inc == triple_b_duty) out_b <= 1'b0;
        if (triple_inc == triple_c_duty) out_c <= 1'b0;
      end
    end
  end

  // Routing enables
  wire fine_neg_route_one  = misc_routing_reg[dual_pwm_pkg::NEG_ROUTE1];
  wire fine_neg_route_zero = misc_routing_reg[dual_pwm_pkg::NEG_ROUTE0];
  wire fine_pos_route_one  = misc_routing_reg[dual_pwm_pkg::POS_ROUTE1];
  wire fine_pos_route_zero = misc_routing_reg[dual_pwm_pkg::POS_ROUTE0];
  wire triple_c_route_three = misc_routing_reg[dual_pwm_pkg::C_ROUTE3];
  wire triple_c_route_two   = misc_routing_reg[dual_pwm_pkg::C_ROUTE2];
  wire triple_c_route_one   = triple_routing_reg[dual_pwm_pkg::C_ROUTE1];
  wire triple_c_route_zero  = triple_routing_reg[dual_pwm_pkg::C_ROUTE0];
  wire triple_b_route_two   = triple_routing_reg[dual_pwm_pkg::B_ROUTE2];
  wire triple_b_route_one   = triple_routing_reg[dual_pwm_pkg::B_ROUTE1];
  wire triple_b_route_zero  = triple_routing_reg[dual_pwm_pkg::B_ROUTE0];
  wire triple_a_route_two   = triple_routing_reg[dual_pwm_pkg::A_ROUTE2];
  wire triple_a_route_one   = triple_routing_reg[dual_pwm_pkg::A_ROUTE1];
  wire triple_a_route_zero  = triple_routing_reg[dual_pwm_pkg::A_ROUTE0];

  wire fpos = fc.fine_positive_output;
  wire fneg = fc.fine_negative_output;

  // Shared pins: the fine channel is checked first and wins
  wire [9:0] drive;
  wire [9:0] level;
  assign drive[dual_pwm_pkg::PIN_PA0] = fine_neg_route_one ||
                                        triple_a_route_one;
  assign level[dual_pwm_pkg::PIN_PA0] = fine_neg_route_one ? fneg : out_a;
  assign drive[dual_pwm_pkg::PIN_PA4] = fine_neg_route_zero ||
                                        triple_b_route_one;
  assign level[dual_pwm_pkg::PIN_PA4] = fine_neg_route_zero ? fneg : out_b;
  assign drive[dual_pwm_pkg::PIN_PB0] = fine_pos_route_one ||
                                        triple_c_route_one;
  assign level[dual_pwm_pkg::PIN_PB0] = fine_pos_route_one ? fpos : out_c;
  assign drive[dual_pwm_pkg::PIN_PA3] = fine_pos_route_zero ||
                                        triple_c_route_two;
  assign level[dual_pwm_pkg::PIN_PA3] = fine_pos_route_zero ? fpos : out_c;

  // Pins owned by the triple part alone
  assign drive[dual_pwm_pkg::PIN_PB1] = triple_a_route_zero;
  assign level[dual_pwm_pkg::PIN_PB1] = out_a;
  assign drive[dual_pwm_pkg::PIN_PD1] = triple_a_route_two;
  assign level[dual_pwm_pkg::PIN_PD1] = out_a;
  assign drive[dual_pwm_pkg::PIN_PD7] = triple_b_route_zero;
  assign level[dual_pwm_pkg::PIN_PD7] = out_b;
  assign drive[dual_pwm_pkg::PIN_PD2] = triple_b_route_two;
  assign level[dual_pwm_pkg::PIN_PD2] = out_b;
  assign drive[dual_pwm_pkg::PIN_PA5] = triple_c_route_zero;
  assign level[dual_pwm_pkg::PIN_PA5] = out_c;
  assign drive[dual_pwm_pkg::PIN_PD3] = triple_c_route_three;
  assign level[dual_pwm_pkg::PIN_PD3] = out_c;

  // Undriven pins show low so the port logic never sees a stale level
  assign pin_out  = level & drive;
  assign pin_oe_n = ~drive;

endmodule

// >>> logic/fine_chan_if.sv
/*
  Carrier between the unit top and the fine (8+2)-bit channel.
  Assumes the top drives settings and the channel returns its outputs.
*/
`timescale 1ns/1ns
interface fine_chan_if;
  logic       tick;
  logic       clear;
  logic [1:0] mode;
  logic [2:0] nov;
  logic [7:0] period;
  logic [7:0] duty_h;
  logic [1:0] duty_l;
  logic [7:0] count;
  logic       fine_positive_output;
  logic       fine_negative_output;

  modport ctrl (output tick, clear, mode, nov, period, duty_h, duty_l,
                input count, fine_positive_output, fine_negative_output);
  modport chan (input tick, clear, mode, nov, period, duty_h, duty_l,
                output count, fine_positive_output, fine_negative_output);
endinterface

// >>> logic/fine_pwm_channel.sv
/*
  Fine (8+2)-bit PWM channel with spread fraction, buffered duty,
  non-overlap gap and four complementary output modes.
  Assumes a single pclk and a one-cycle channel clock enable on tick.
*/
`timescale 1ns/1ns
module fine_pwm_channel (
  input  wire logic  pclk,
  input  wire logic  presetn,
  fine_chan_if.chan  c
);
  logic [7:0] cnt;
  logic [7:0] duty_h_buf;
  logic [1:0] duty_l_buf;
  logic [1:0] phase;
  logic       late;
  logic       raw;
  logic       raw_seen;
  logic [3:0] dead;
  logic       pos;
  logic       neg;

  // Rollover, next count and spread decision
  wire        roll       = (cnt == c.period);
  wire [7:0]  cnt_inc    = cnt + 8'h01;
  wire [1:0]  next_phase = phase + 2'b01;
  wire        start_late = (next_phase < c.duty_l);
  wire [3:0]  gap        = dual_pwm_pkg::nov_gap(c.nov);
  wire        settled    = (dead == 4'h0);

  // Base counter, duty buffer and raw waveform
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      duty_h_buf <= 8'h00;
      duty_l_buf <= 2'b00;
      phase <= 2'b00;
      late <= 1'b0;
      raw <= 1'b0;
    end else if (c.clear) begin
      cnt <= 8'h00;
      duty_h_buf <= c.duty_h;
      duty_l_buf <= c.duty_l;
      phase <= 2'b00;
      late <= 1'b0;
      raw <= 1'b0;
    end else if (c.tick) begin
      if (roll) begin
        cnt <= 8'h00;
        duty_h_buf <= c.duty_h;
        duty_l_buf <= c.duty_l;
        phase <= next_phase;
        late <= start_late;
        raw <= (c.duty_h != 8'h00) && !start_late;
      end else begin
        // Runs through 8-bit wrap when period is below count
        cnt <= cnt_inc;
        late <= 1'b0;
        if (cnt_inc == duty_h_buf) begin
          raw <= 1'b0;
        end else if (late && (duty_h_buf != 8'h00)) begin
          raw <= 1'b1;
        end
      end
    end
  end

  // Dead time: each edge of the raw wave waits out the gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_seen <= 1'b0;
      dead <= 4'h0;
    end else if (c.clear) begin
      raw_seen <= 1'b0;
      dead <= 4'h0;
    end else if (raw != raw_seen) begin
      raw_seen <= raw;
      dead <= gap;
    end else if (c.tick && !settled) begin
      dead <= dead - 4'h1;
    end
  end

  assign pos = raw_seen && settled;
  assign neg = !raw_seen && settled;

  // Output mode mapping, registered; both low while cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c.fine_positive_output <= 1'b0;
      c.fine_negative_output <= 1'b0;
    end else if (c.clear) begin
      c.fine_positive_output <= 1'b0;
      c.fine_negative_output <= 1'b0;
    end else begin
      case (dual_pwm_pkg::out_mode_t'(c.mode))
        dual_pwm_pkg::MODE_DIRECT: begin
          c.fine_positive_output <= pos;
          c.fine_negative_output <= neg;
        end
        dual_pwm_pkg::MODE_INVERTED: begin
          c.fine_positive_output <= !pos;
          c.fine_negative_output <= !neg;
        end
        dual_pwm_pkg::MODE_SWAPPED: begin
          c.fine_positive_output <= neg;
          c.fine_negative_output <= pos;
        end
        default: begin
          c.fine_positive_output <= !neg;
          c.fine_negative_output <= !pos;
        end
      endcase
    end
  end

  assign c.count = cnt;

endmodule

// >>> testbench/dual_pwm_unit_sva.sv
/*
  Port checker for the dual PWM unit, bound to its top.
  Assumes register writes land at the APB access edge.
*/
`timescale 1ns/1ns
module dual_pwm_unit_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc16_tick,
  input wire logic        osc32_tick,
  input wire logic [9:0]  pin_out,
  input wire logic [9:0]  pin_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Decode of the map; anything else must be refused
  wire [7:0] ix  = paddr[9:2];
  wire       hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 &&
                   ix >= 8'h92 && ix <= 8'h9d;
  wire       acc = psel && penable;
  logic [7:0] tr, mr, fc, cc;
  // Shadows let the pins be judged from bus traffic alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr <= 8'h00;
      mr <= 8'h00;
      fc <= 8'h00;
      cc <= 8'h00;
    end else if (acc && pwrite && hit) begin
      if (ix == 8'h9b) tr <= pwdata[7:0];
      if (ix == 8'h9c) mr <= pwdata[7:0];
      if (ix == 8'h95) fc <= pwdata[7:0];
      if (ix == 8'h96) cc <= pwdata[7:0];
    end
  end
  a_miss_err: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  a_hit_ok: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  a_miss_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_pa0_route: assert property (pin_oe_n[0] == !(mr[3] | tr[1]))
    else $error("pin 0 enable wrong");
  a_pb0_route: assert property (pin_oe_n[4] == !(mr[1] | tr[7]))
    else $error("pin 4 enable wrong");
  a_pa5_route: assert property (pin_oe_n[3] == !tr[6])
    else $error("pin 3 enable wrong");
  a_triple_off: assert property (cc[7] [*3] |-> !pin_out[3])
    else $error("disabled triple channel drives high");
  a_clear_low: assert property
    ((fc[5] && fc[4:3] == 2'h0 && mr[0]) [*5] |-> !pin_out[1])
    else $error("cleared fine channel drives high");
endmodule
bind dual_pwm_unit dual_pwm_unit_sva i_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc16_tick(osc16_tick),
  .osc32_tick(osc32_tick), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// >>> testbench/pin_load.sv
/*
  Load at the unit's pins: a weak pull-down on each pin.
  Assumes pin_oe_n low means the unit drives that pin.
*/
`timescale 1ns/1ns
module pin_load (
  input  wire logic [9:0] pin_out,
  input  wire logic [9:0] pin_oe_n,
  output logic      [9:0] pin_level
);
  // A released pin sinks to the pull-down, never keeps its last value
  assign pin_level = ~pin_oe_n & pin_out;
endmodule

// >>> testbench/testbench.sv
/*
  Self-checking bench for the dual PWM unit over APB.
  Assumes the checker binds itself and the pins see pin_load.
*/
`timescale 1ns/1ns
module testbench;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, osc16_tick = 1'b0, osc32_tick = 1'b0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr;
  logic [9:0]  pin_out, pin_oe_n, level;
  logic [1:0]  ph = 2'h0;
  int          fails = 0, samples_checked = 0, hi, ri;
  always #10 pclk = ~pclk;
  // Oscillator enables: one pclk in three, and two in three
  always @(posedge pclk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    osc16_tick <= (ph == 2'h0);
    osc32_tick <= (ph != 2'h0);
  end
  dual_pwm_unit i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc16_tick(osc16_tick), .osc32_tick(osc32_tick),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pin_load i_load (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(level));
  task automatic check_cnt(input int got, input int want);
    samples_checked++;
    if (got != want) begin
      fails++;
      $display("ERROR %0t count %0d expected %0d", $time, got, want);
    end
  endtask
  task automatic check_reg(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("ERROR %0t read %h expected %h", $time, got, want);
    end
  endtask
  // One APB transfer; a is upper address bits plus register index
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle limit here: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Settle, then count high samples and rising edges over 768 pclks
  task automatic measure(input int p);
    logic prev;
    repeat (600) @(posedge pclk);
    #1 prev = level[p];
    hi = 0;
    ri = 0;
    repeat (768) begin
      @(posedge pclk);
      #1;
      hi += int'(level[p] === 1'b1);
      ri += int'(level[p] === 1'b1 && prev !== 1'b1);
      prev = level[p];
    end
    @(posedge pclk);
  endtask
  task automatic t_regs();
    for (int i = 8'h92; i <= 8'h9c; i++) begin
      apb(1'b0, 10'(i), 8'h00);
      check_reg(rd[7:0], (i == 8'h92 || i == 8'h97) ? 8'hff : 8'h00);
    end
    apb(1'b0, 10'h091, 8'h00);
    check_reg({7'h00, er}, 8'h01);
    apb(1'b1, 10'h100, 8'h55);
    check_reg({7'h00, er}, 8'h01);
  endtask
  // Sources and prescalers seen as edge rate of triple A on its pin
  task automatic t_clock();
    logic [7:0] ctl[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h30};
    int rises[7] = '{192, 96, 48, 3, 192, 64, 128};
    apb(1'b1, 10'h097, 8'h03);
    apb(1'b1, 10'h098, 8'h02);
    apb(1'b1, 10'h09b, 8'h01);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 10'h096, ctl[k]);
      measure(dual_pwm_pkg::PIN_PB1);
      check_cnt(hi, 384);
      check_cnt(ri, rises[k]);
    end
    apb(1'b1, 10'h096, 8'h00);
  endtask
  task automatic t_triple();
    int pins[3] = '{dual_pwm_pkg::PIN_PB1, dual_pwm_pkg::PIN_PD7,
                    dual_pwm_pkg::PIN_PA5};
    apb(1'b1, 10'h09b, 8'h49);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 10'(8'h98 + k), 8'(k + 1));
      measure(pins[k]);
      check_cnt(hi, 192 * (k + 1));
    end
    apb(1'b1, 10'h096, 8'h80);
    measure(dual_pwm_pkg::PIN_PA5);
    check_cnt(hi, 0);
    apb(1'b1, 10'h097, 8'hff);
    apb(1'b1, 10'h096, 8'h00);
    // Shrink the period below the live count: it must run on, not restart
    repeat (20) @(posedge pclk);
    apb(1'b1, 10'h097, 8'h03);
    apb(1'b0, 10'h09d, 8'h00);
    check_cnt(int'(rd[15:8] > 8'h03), 1);
  endtask
  // Fine neg and triple A share a pin; modes and clear on duty 0
  task automatic t_modes();
    logic [7:0] ctl[5] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20};
    int want[5] = '{768, 0, 0, 768, 0};
    apb(1'b1, 10'h09c, 8'h09);
    apb(1'b1, 10'h09b, 8'h02);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 10'h095, ctl[k]);
      measure(dual_pwm_pkg::PIN_PA0);
      check_cnt(hi, want[k]);
    end
    apb(1'b1, 10'h095, 8'h00);
  endtask
  task automatic t_dither();
    apb(1'b1, 10'h092, 8'h03);
    apb(1'b1, 10'h093, 8'h02);
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, 10'h094, 8'(l));
      measure(dual_pwm_pkg::PIN_PA3);
      check_cnt(hi, 48 * (8 - l));
    end
    // Fine clock off: the fine count must not move between two reads
    apb(1'b1, 10'h096, 8'h40);
    apb(1'b0, 10'h09d, 8'h00);
    hi = int'(rd[7:0]);
    apb(1'b0, 10'h09d, 8'h00);
    check_reg(rd[7:0], 8'(hi));
    apb(1'b1, 10'h096, 8'h00);
  endtask
  // Each gap eats that many ticks from the high part of a cycle
  task automatic t_gap();
    apb(1'b1, 10'h092, 8'h0f);
    apb(1'b1, 10'h093, 8'h0a);
    apb(1'b1, 10'h094, 8'h00);
    for (int c = 0; c < 7; c++) begin
      apb(1'b1, 10'h095, 8'(c));
      measure(dual_pwm_pkg::PIN_PA3);
      check_cnt(hi, 48 * (10 - ((c == 0 || c > 5) ? 0 : c + 3)));
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_clock();
    t_triple();
    t_modes();
    t_dither();
    t_gap();
    wrap_up();
  end
  // Watchdog well beyond the roughly 40000 cycles the tests need
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    wrap_up();
  end
endmodule
